// ===== core/bfbt_core.v
// Breaker failure supervision stage with backup trip, counters, force flag and fault log, APB register access.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "bfbt_defines.vh"
module bfbt_core #(
  parameter NUM_OUT = 14,
  parameter OPT_W = 20,
  parameter CNT_W = 16,
  parameter MS_CYCLES = `BFBT_MS_NS / `BFBT_CLK_PERIOD_NS,
  parameter FORCE_TIMEOUT_MS = `BFBT_FORCE_TIMEOUT_MIN * `BFBT_MS_PER_MIN,
  parameter [31:0] UNLOCK_KEY = 32'h00005A5A // Arbitrary key value.
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [NUM_OUT-1:0] trip_drive,
  input wire [31:0] rtc_date,
  input wire [31:0] rtc_time_ms,
  output reg backup_trip,
  output wire irq
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [2:0] ctrl_reg;
  reg force_reg;
  reg unlock_reg;
  reg [3:0] select_reg;
  reg [OPT_W-1:0] optime_reg;
  reg [CNT_W-1:0] start_event_count;
  reg [CNT_W-1:0] trip_event_count;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] fault_sel_reg;
  reg [2:0] wr_ptr_reg;
  reg [3:0] fault_num_reg;
  reg [31:0] ms_div_reg;
  reg [31:0] force_ms_reg;
  reg [OPT_W-1:0] elapsed_ms_reg;
  reg [23:0] pct_acc_reg;
  reg [7:0] elapsed_delay_percent;
  reg start_reg;
  reg trip_reg;
  reg sup_d_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire acc = psel & penable & clk_en;
  wire wr = acc & pwrite;
  reg addr_ok;
  reg [31:0] rd_mux;
  wire [71:0] rec_rdata;

  // Hold the transfer while the clock enable freezes the block.
  assign pready = clk_en;
  assign pslverr = psel & penable & ~addr_ok;

  // Address check and read data selection.
  always @* begin
    addr_ok = 1'b1;
    rd_mux = 32'h00000000;
    if (paddr == `BFBT_ADDR_CTRL) begin
      rd_mux[2:0] = ctrl_reg;
    end else if (paddr == `BFBT_ADDR_STATUS) begin
      rd_mux[`BFBT_ST_BLOCKED] = ctrl_reg[`BFBT_CTRL_BLOCK];
      rd_mux[`BFBT_ST_START] = start_reg | ctrl_reg[`BFBT_CTRL_FSTART];
      rd_mux[`BFBT_ST_TRIP] = trip_reg | ctrl_reg[`BFBT_CTRL_FTRIP];
      rd_mux[`BFBT_ST_FORCE] = force_reg;
      rd_mux[`BFBT_ST_UNLOCKED] = unlock_reg;
    end else if (paddr == `BFBT_ADDR_START_CNT) begin
      rd_mux[CNT_W-1:0] = start_event_count;
    end else if (paddr == `BFBT_ADDR_TRIP_CNT) begin
      rd_mux[CNT_W-1:0] = trip_event_count;
    end else if (paddr == `BFBT_ADDR_FORCE) begin
      rd_mux[0] = force_reg;
    end else if (paddr == `BFBT_ADDR_SELECT) begin
      rd_mux[3:0] = select_reg;
    end else if (paddr == `BFBT_ADDR_OPTIME) begin
      rd_mux[OPT_W-1:0] = optime_reg;
    end else if (paddr == `BFBT_ADDR_PASSWORD) begin
      rd_mux[0] = unlock_reg;
    end else if (paddr == `BFBT_ADDR_IRQ_STATUS) begin
      rd_mux[2:0] = irq_status_reg;
    end else if (paddr == `BFBT_ADDR_IRQ_MASK) begin
      rd_mux[2:0] = irq_mask_reg;
    end else if (paddr == `BFBT_ADDR_FAULT_SEL) begin
      rd_mux[2:0] = fault_sel_reg;
      rd_mux[11:8] = fault_num_reg;
    end else if (paddr == `BFBT_ADDR_FAULT_DATE) begin
      rd_mux = rec_rdata[71:40];
    end else if (paddr == `BFBT_ADDR_FAULT_TIME) begin
      rd_mux = rec_rdata[39:8];
    end else if (paddr == `BFBT_ADDR_FAULT_DELAY) begin
      rd_mux[7:0] = rec_rdata[7:0];
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data is captured in the setup cycle so it stands steady for the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  wire wr_ok = wr & addr_ok;
  wire wr_set = wr_ok & unlock_reg;

  // ------------------------------------------------------------
  // Supervision and timing
  // ------------------------------------------------------------
  wire sel_valid = (select_reg != 4'h0) && (select_reg <= `BFBT_SELECT_MAX);
  wire [3:0] sel_idx = select_reg - 4'h1;
  wire supervised = sel_valid & trip_drive[sel_idx];
  wire blocked = ctrl_reg[`BFBT_CTRL_BLOCK];
  wire ms_tick = (ms_div_reg == MS_CYCLES - 1);
  wire running = supervised & ~blocked;
  wire time_up = running & ~trip_reg & (elapsed_ms_reg >= optime_reg);
  wire start_rise = running & ~start_reg;
  wire force_to = force_reg & ms_tick & (force_ms_reg == FORCE_TIMEOUT_MS - 1);
  wire pct_ge = pct_acc_reg >= {{(24-OPT_W){1'b0}}, optime_reg};
  wire episode_end = start_reg & ~running;
  wire rec_we = time_up | (episode_end & ~trip_reg);
  wire [7:0] rec_pct = time_up ? `BFBT_PCT_TRIP : elapsed_delay_percent;

  // Millisecond prescaler; free-running so the operate timer and the force timeout share one base.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_reg <= 32'h00000000;
    end else if (clk_en) begin
      ms_div_reg <= ms_tick ? 32'h00000000 : ms_div_reg + 32'h00000001;
    end
  end

  // Stage state: start, trip, elapsed time and the percentage of the operate time.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      backup_trip <= 1'b0;
      sup_d_reg <= 1'b0;
      elapsed_ms_reg <= {OPT_W{1'b0}};
      pct_acc_reg <= 24'h000000;
      elapsed_delay_percent <= 8'h00;
    end else if (clk_en) begin
      sup_d_reg <= supervised;
      start_reg <= running;
      if (!running) begin
        // Released or blocked: clear the timer and drop the backup trip.
        trip_reg <= 1'b0;
        elapsed_ms_reg <= {OPT_W{1'b0}};
        pct_acc_reg <= 24'h000000;
        elapsed_delay_percent <= 8'h00;
      end else begin
        if (time_up) begin
          trip_reg <= 1'b1;
        end
        if (ms_tick && !trip_reg) begin
          elapsed_ms_reg <= elapsed_ms_reg + {{(OPT_W-1){1'b0}}, 1'b1};
        end
        // One division step per cycle turns elapsed time into percent of the operate time.
        pct_acc_reg <= pct_acc_reg + ((ms_tick && !trip_reg) ? `BFBT_PCT_STEP : 24'h000000)
                       - (pct_ge ? {{(24-OPT_W){1'b0}}, optime_reg} : 24'h000000);
        if (pct_ge && elapsed_delay_percent != `BFBT_PCT_TRIP) begin
          elapsed_delay_percent <= elapsed_delay_percent + 8'h01;
        end
      end
      // Backup trip sets on timeout or force and holds until the primary output resets or the block bit is set.
      backup_trip <= (backup_trip & running) | time_up | (ctrl_reg[`BFBT_CTRL_FTRIP] & force_reg);
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
      force_reg <= 1'b0;
      force_ms_reg <= 32'h00000000;
      unlock_reg <= 1'b0;
      select_reg <= `BFBT_SELECT_RST;
      optime_reg <= `BFBT_OPTIME_RST;
      start_event_count <= {CNT_W{1'b0}};
      trip_event_count <= {CNT_W{1'b0}};
      irq_mask_reg <= 3'h0;
      fault_sel_reg <= 3'h0;
    end else if (clk_en) begin
      // Force flag: password-protected set, automatic clear after its timeout.
      if (force_to) begin
        force_reg <= 1'b0;
      end else if (wr_set && paddr == `BFBT_ADDR_FORCE) begin
        force_reg <= pwdata[0];
      end
      if (!force_reg || (wr_set && paddr == `BFBT_ADDR_FORCE)) begin
        force_ms_reg <= 32'h00000000;
      end else if (ms_tick) begin
        force_ms_reg <= force_ms_reg + 32'h00000001;
      end
      // Forced bits only stick while the force flag is on; they drop with it.
      if (wr_ok && paddr == `BFBT_ADDR_CTRL) begin
        ctrl_reg[`BFBT_CTRL_BLOCK] <= pwdata[`BFBT_CTRL_BLOCK];
        ctrl_reg[2:1] <= force_reg ? pwdata[2:1] : 2'b00;
      end else if (!force_reg || force_to) begin
        ctrl_reg[2:1] <= 2'b00;
      end
      if (wr_ok && paddr == `BFBT_ADDR_PASSWORD) begin
        unlock_reg <= (pwdata == UNLOCK_KEY);
      end
      if (wr_set && paddr == `BFBT_ADDR_SELECT) begin
        select_reg <= pwdata[3:0];
      end
      if (wr_set && paddr == `BFBT_ADDR_OPTIME) begin
        optime_reg <= pwdata[OPT_W-1:0];
      end
      // Counters: an event in the clearing cycle still counts.
      if (start_rise) begin
        start_event_count <= (wr_ok && paddr == `BFBT_ADDR_START_CNT) ? {{(CNT_W-1){1'b0}}, 1'b1}
                             : start_event_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (wr_ok && paddr == `BFBT_ADDR_START_CNT) begin
        start_event_count <= {CNT_W{1'b0}};
      end
      if (time_up) begin
        trip_event_count <= (wr_ok && paddr == `BFBT_ADDR_TRIP_CNT) ? {{(CNT_W-1){1'b0}}, 1'b1}
                            : trip_event_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (wr_ok && paddr == `BFBT_ADDR_TRIP_CNT) begin
        trip_event_count <= {CNT_W{1'b0}};
      end
      if (wr_ok && paddr == `BFBT_ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[2:0];
      end
      if (wr_ok && paddr == `BFBT_ADDR_FAULT_SEL) begin
        fault_sel_reg <= pwdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  wire [2:0] irq_events = {force_to, time_up, start_rise};
  wire [2:0] irq_w1c = (wr_ok && paddr == `BFBT_ADDR_IRQ_STATUS) ? pwdata[2:0] : 3'h0;

  // Sticky bits; a new event wins over a clear in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 3'h0;
    end else if (clk_en) begin
      irq_status_reg <= (irq_status_reg & ~irq_w1c) | irq_events;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // Fault log
  // ------------------------------------------------------------
  // Ring of eight; index 0 in the selector always means the newest record.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= 3'h0;
      fault_num_reg <= 4'h0;
    end else if (clk_en && rec_we) begin
      wr_ptr_reg <= wr_ptr_reg + 3'h1;
      if (fault_num_reg != 4'h8) begin
        fault_num_reg <= fault_num_reg + 4'h1;
      end
    end
  end

  bfbt_fault_mem #(
    .WIDTH(72),
    .AW(3)
  ) u_fault_mem (
    .pclk(pclk),
    .clk_en(clk_en),
    .wr_en(rec_we),
    .wr_addr(wr_ptr_reg),
    .wr_data({rtc_date, rtc_time_ms, rec_pct}),
    .rd_addr(wr_ptr_reg - 3'h1 - fault_sel_reg),
    .rd_data(rec_rdata)
  );

endmodule // bfbt_core

// ===== core/bfbt_defines.vh
// Register map, field positions, reset values and timing figures of the breaker failure backup trip block.
`ifndef BFBT_DEFINES_VH
`define BFBT_DEFINES_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define BFBT_ADDR_CTRL 8'h00
`define BFBT_ADDR_STATUS 8'h04
`define BFBT_ADDR_START_CNT 8'h08
`define BFBT_ADDR_TRIP_CNT 8'h0C
`define BFBT_ADDR_FORCE 8'h10
`define BFBT_ADDR_SELECT 8'h14
`define BFBT_ADDR_OPTIME 8'h18
`define BFBT_ADDR_PASSWORD 8'h1C
`define BFBT_ADDR_IRQ_STATUS 8'h20
`define BFBT_ADDR_IRQ_MASK 8'h24
`define BFBT_ADDR_FAULT_SEL 8'h28
`define BFBT_ADDR_FAULT_DATE 8'h2C
`define BFBT_ADDR_FAULT_TIME 8'h30
`define BFBT_ADDR_FAULT_DELAY 8'h34

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BFBT_CTRL_BLOCK 0
`define BFBT_CTRL_FSTART 1
`define BFBT_CTRL_FTRIP 2
`define BFBT_ST_BLOCKED 0
`define BFBT_ST_START 1
`define BFBT_ST_TRIP 2
`define BFBT_ST_FORCE 3
`define BFBT_ST_UNLOCKED 4
`define BFBT_IRQ_START 0
`define BFBT_IRQ_TRIP 1
`define BFBT_IRQ_FTMO 2

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define BFBT_SELECT_RST 4'h1
`define BFBT_SELECT_MAX 4'hE
`define BFBT_OPTIME_RST 20'h000C8
`define BFBT_PCT_TRIP 8'h64
`define BFBT_PCT_STEP 24'h000064

// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define BFBT_CLK_PERIOD_NS 10
`define BFBT_MS_NS 1000000
`define BFBT_FORCE_TIMEOUT_MIN 5
`define BFBT_MS_PER_MIN 60000

`endif

// ===== core/bfbt_fault_mem.v
// Fault record memory: one write port, registered read port.
`timescale 1ns/10ps
module bfbt_fault_mem #(
  parameter WIDTH = 72,
  parameter AW = 3
) (
  input wire pclk,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Contents carry no reset; the core tracks which entries are valid.
  always @(posedge pclk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule // bfbt_fault_mem

// ===== tb/bfbt_core_asserts.sv
// Port-level concurrent checks for the breaker failure backup trip block.
`timescale 1ns/10ps
module bfbt_core_asserts #(
  parameter NUM_OUT = 14
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [NUM_OUT-1:0] trip_drive,
  input wire [31:0] rtc_date,
  input wire [31:0] rtc_time_ms,
  input wire backup_trip,
  input wire irq
);
  // ------------------------------
  // Checks
  // ------------------------------
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_follows_a: assert property (pready == clk_en) else $error("pready differs from clk_en");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  slverr_unmapped_a: assert property (psel && penable && paddr > 8'h34 |-> pslverr)
    else $error("no pslverr on unmapped address");
  slverr_mapped_a: assert property (psel && penable && paddr <= 8'h34 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("pslverr on mapped address");
  reset_quiet_a: assert property (disable iff (1'b0) !presetn |-> !backup_trip && !irq && prdata == 32'h0)
    else $error("outputs active in reset");
  freeze_hold_a: assert property (!clk_en |=> $stable(backup_trip)) else $error("backup trip moved while frozen");
  trip_cause_a: assert property ($rose(backup_trip) |-> $past(|trip_drive))
    else $error("backup trip without trip drive");
  trip_release_a: assert property (backup_trip && trip_drive == 0 && clk_en |-> ##[1:2] !backup_trip)
    else $error("backup trip held after release");
endmodule // bfbt_core_asserts

bind bfbt_core bfbt_core_asserts #(.NUM_OUT(NUM_OUT)) u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .trip_drive(trip_drive), .rtc_date(rtc_date),
  .rtc_time_ms(rtc_time_ms), .backup_trip(backup_trip), .irq(irq));

// ===== tb/bfbt_stage_model.sv
// Far-side model: protection stages whose trips are combined onto the trip outputs.
`timescale 1ns/10ps
module bfbt_stage_model (
  input wire pclk,
  input wire presetn,
  input wire [13:0] req_a,
  input wire [13:0] req_b,
  output reg [13:0] trip_drive
);
  // ------------------------------
  // Output matrix
  // ------------------------------
  // Every output is the OR of all stages routed to it; the backup trip is never one of them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_drive <= 14'h0000;
    end else begin
      trip_drive <= req_a | req_b;
    end
  end
endmodule // bfbt_stage_model

// ===== tb/testbench.sv
// Self-checking bench for the breaker failure backup trip block.
`timescale 1ns/10ps
`include "bfbt_defines.vh"
module testbench;
  localparam int MSC = 10;
  localparam logic [31:0] F = 32'hFFFFFFFF;
  logic pclk = 0, presetn = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, backup_trip, irq, perr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rtc_date = 0, rtc_time_ms = 0, q, t1, seed = 32'h1dc14e63;
  logic [13:0] req_a = 0, req_b = 0, trip_drive;
  logic [3:0] sel;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n;
  // ------------------------------
  // Clock, design, stages and timeout
  // ------------------------------
  initial begin
    forever #5 pclk = ~pclk;
  end
  bfbt_core #(.MS_CYCLES(MSC), .FORCE_TIMEOUT_MS(5)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .trip_drive(trip_drive), .rtc_date(rtc_date),
    .rtc_time_ms(rtc_time_ms), .backup_trip(backup_trip), .irq(irq));
  bfbt_stage_model stages (.pclk(pclk), .presetn(presetn), .req_a(req_a), .req_b(req_b), .trip_drive(trip_drive));
  // The whole sequence needs about six hundred cycles, so this ceiling only catches a hang.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // The log keeps only the eight newest episodes.
  function automatic logic [31:0] held(input int e);
    return (e > 8 ? 8 : e) << 8;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the bench timeout ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, q & m);
  endtask
  task automatic wait_bt(input logic v);
    n = 0;
    while (backup_trip !== v && n < 500) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    // A real falling edge at time zero lets the asynchronous reset act before the first clock edge.
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    seed = lfsr(seed);
    rtc_date <= seed;
    rtc_time_ms <= lfsr(seed);
    rdc("select", `BFBT_ADDR_SELECT, F, 1);
    apb(1, `BFBT_ADDR_OPTIME, 3);
    rdc("locked optime", `BFBT_ADDR_OPTIME, F, 200);
    apb(0, 8'h3C, 0);
    chk("unmapped", 1, perr);
    apb(1, `BFBT_ADDR_PASSWORD, 32'h00005A5A);
    apb(1, `BFBT_ADDR_OPTIME, 3);
    rdc("optime", `BFBT_ADDR_OPTIME, F, 3);
    seed = lfsr(seed);
    sel = 4'(seed % 14 + 1);
    apb(1, `BFBT_ADDR_SELECT, sel);
    apb(1, `BFBT_ADDR_IRQ_MASK, 2);
    $display("test registers done");
    // A stage on an unsupervised output must not start the timer.
    req_a <= 14'h1 << (sel % 14);
    repeat (40) @(posedge pclk);
    chk("idle", 0, backup_trip);
    rdc("no start", `BFBT_ADDR_STATUS, 6, 0);
    req_a <= 0;
    // A second stage on the supervised output starts the failure timing.
    req_b <= 14'h1 << (sel - 1);
    wait_bt(1);
    chk("delay", 1, n >= 2 * MSC && n <= 3 * MSC + 4);
    repeat (30) @(posedge pclk);
    chk("hold", 1, backup_trip);
    rdc("status", `BFBT_ADDR_STATUS, 6, 6);
    chk("irq", 1, irq);
    req_b <= 0;
    wait_bt(0);
    chk("release", 1, n <= 3);
    rdc("starts", `BFBT_ADDR_START_CNT, F, 1);
    rdc("trips", `BFBT_ADDR_TRIP_CNT, F, 1);
    apb(1, `BFBT_ADDR_FAULT_SEL, 0);
    rdc("pct", `BFBT_ADDR_FAULT_DELAY, 32'hFF, 100);
    rdc("date", `BFBT_ADDR_FAULT_DATE, F, rtc_date);
    rdc("time", `BFBT_ADDR_FAULT_TIME, F, rtc_time_ms);
    apb(1, `BFBT_ADDR_IRQ_STATUS, 2);
    #1;
    chk("irq clear", 0, irq);
    $display("test trip done");
    // Blocked stage: nothing starts however long the drive lasts.
    apb(1, `BFBT_ADDR_CTRL, 1);
    req_b <= 14'h1 << (sel - 1);
    repeat (50) @(posedge pclk);
    chk("blocked", 0, backup_trip);
    rdc("blk status", `BFBT_ADDR_STATUS, 7, 1);
    req_b <= 0;
    apb(1, `BFBT_ADDR_CTRL, 0);
    rdc("blk starts", `BFBT_ADDR_START_CNT, F, 1);
    apb(1, `BFBT_ADDR_START_CNT, 32'h1234);
    rdc("cleared", `BFBT_ADDR_START_CNT, F, 0);
    apb(1, `BFBT_ADDR_TRIP_CNT, 32'h00000005);
    rdc("trip cleared", `BFBT_ADDR_TRIP_CNT, F, 0);
    $display("test block done");
    // Short random episodes overflow the fault log without a trip.
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      req_b <= 14'h1 << (sel - 1);
      rtc_time_ms <= seed;
      // The second episode becomes the oldest record still held.
      if (i == 1) begin
        t1 = seed;
      end
      repeat (2 + seed[3:0]) @(posedge pclk);
      req_b <= 0;
      repeat (12) @(posedge pclk);
    end
    rdc("starts", `BFBT_ADDR_START_CNT, F, 9);
    rdc("held", `BFBT_ADDR_FAULT_SEL, 32'hF00, held(10));
    apb(1, `BFBT_ADDR_FAULT_SEL, 0);
    apb(0, `BFBT_ADDR_FAULT_DELAY, 0);
    chk("pct partial", 1, q[7:0] < 100);
    apb(1, `BFBT_ADDR_FAULT_SEL, 7);
    rdc("oldest", `BFBT_ADDR_FAULT_TIME, F, t1);
    $display("test log done");
    // Forcing is refused until the flag is set, and the flag times out.
    apb(1, `BFBT_ADDR_CTRL, 2);
    rdc("no force", `BFBT_ADDR_CTRL, 2, 0);
    apb(1, `BFBT_ADDR_FORCE, 1);
    apb(1, `BFBT_ADDR_CTRL, 2);
    rdc("forced", `BFBT_ADDR_CTRL, 2, 2);
    rdc("force on", `BFBT_ADDR_STATUS, 8, 8);
    repeat (70) @(posedge pclk);
    rdc("force off", `BFBT_ADDR_STATUS, 8, 0);
    rdc("timeout irq", `BFBT_ADDR_IRQ_STATUS, 4, 4);
    rdc("force bits", `BFBT_ADDR_CTRL, 6, 0);
    $display("test force done");
    // A frozen block, then relocking refuses setting writes.
    clk_en <= 0;
    repeat (4) @(posedge pclk);
    clk_en <= 1;
    apb(1, `BFBT_ADDR_PASSWORD, 0);
    apb(1, `BFBT_ADDR_SELECT, sel % 14 + 1);
    rdc("relocked", `BFBT_ADDR_SELECT, F, sel);
    $display("test lock done");
    // A second reset in mid-run restores the defaults and locks the settings again.
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdc("reset select", `BFBT_ADDR_SELECT, F, 1);
    rdc("reset status", `BFBT_ADDR_STATUS, 32'h1F, 0);
    $display("test reset done");
    report_and_stop();
  end
endmodule // testbench
